// file: hw/sbi_consts.svh
`ifndef SBI_CONSTS_SVH
`define SBI_CONSTS_SVH
`define SBI_ADDR_W   4
`define SBI_LANES    4
`define SBI_LANE_W   9
`define SBI_DATA_W   36
`define SBI_WORDS    32
`define SBI_NARROW_EN 36'h0_0003_ffff
`define SBI_WIDE_EN   36'hf_ffff_ffff
`endif

// file: hw/sbi_pkg.sv
`include "sbi_consts.svh"
package sbi_pkg;
    typedef logic [`SBI_ADDR_W-1:0] sbi_addr_t;
    typedef logic [`SBI_DATA_W-1:0] sbi_data_t;
    typedef logic [`SBI_LANES-1:0]  sbi_mask_t;

    // pin bundle as it passes the synchroniser
    typedef struct packed {
        logic      k;
        logic      k_comp;
        logic      load_n;
        logic      rd_sel;
        sbi_addr_t addr;
        sbi_data_t data;
        sbi_mask_t mask_n;
    } sbi_pins_s;

    typedef struct packed {
        logic      valid;
        sbi_addr_t addr;
    } sbi_req_s;

    // posted write: both words and their masks, committed on the next write
    typedef struct packed {
        logic      valid;
        sbi_addr_t addr;
        sbi_data_t w0;
        sbi_data_t w1;
        sbi_mask_t m0;
        sbi_mask_t m1;
    } sbi_post_s;
endpackage

// file: hw/sbi_top.sv
// Behaviour
// - load and rd_sel low at a true rise start a write, data one cycle later on true then comp.
// - load low, rd_sel high starts a read; words leave at comp rise t+2 and true rise t+3.
// - after power-up the data bus is deselected and not driven until an operation is issued.
// - with both clocks stopped all outputs hold; parking both clocks high is only advised.
// - each access moves two words, the first at the latched address, the second at the next.
// - write data is taken and read data given on rises of both the true and complemented clocks.
// - narrow: mask 0 gates bits 8..0 and mask 1 bits 17..9; low writes, high keeps.
// - wide: four masks gate the four 9-bit lanes up to bit 35; low writes, high keeps.
// - a data edge with every mask high writes nothing to the array.
// - the masks may change between the two data edges and each word uses its own sampled mask.
// - once reads stop the pending burst ends and the bus is freed after the next comp rise.
// - a write is posted until the next write commits it; reading its address gets posted data.
`include "sbi_consts.svh"
module sbi_top #(
    parameter bit NARROW = 1'b0                       // 1: 18-bit organisation
) (
    input  wire logic                   core_clk,         // system clock
    input  wire logic                   rst,              // synchronous reset
    input  wire logic                   k_pin,            // true input clock
    input  wire logic                   k_comp_pin,       // complemented input clock
    input  wire logic                   address_latch_n,  // load strobe
    input  wire logic                   rd_sel,           // high read, low write
    input  wire sbi_pkg::sbi_addr_t     addr,             // burst address
    input  wire sbi_pkg::sbi_data_t     dq_in,            // data pins, input side
    input  wire sbi_pkg::sbi_mask_t     lane_write_mask_n,// byte-lane selects
    output logic [`SBI_DATA_W-1:0]      dq_out,           // data pins, output side
    output logic                        dq_oe             // data pins drive enable
);
    // ==========================================================
    // pin synchroniser and edge detection
    sbi_pkg::sbi_pins_s pin_raw;
    sbi_pkg::sbi_pins_s pin_s1_q;
    sbi_pkg::sbi_pins_s pin_s2_q;
    logic               k_prev_q;
    logic               kc_prev_q;

    assign pin_raw = '{k: k_pin, k_comp: k_comp_pin, load_n: address_latch_n, rd_sel: rd_sel,
                       addr: addr, data: dq_in, mask_n: lane_write_mask_n};

    // clocks park high in reset so a clock already high at release is not taken as a rise
    localparam sbi_pkg::sbi_pins_s PIN_IDLE = '{k: 1'b1, k_comp: 1'b1, load_n: 1'b1, rd_sel: 1'b0,
                                                addr: '0, data: '0, mask_n: '1};

    // clocks and data share one synchroniser so they stay aligned
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_s1_q  <= PIN_IDLE;
            pin_s2_q  <= PIN_IDLE;
            k_prev_q  <= 1'b1;
            kc_prev_q <= 1'b1;
        end else begin
            pin_s1_q  <= pin_raw;
            pin_s2_q  <= pin_s1_q;
            k_prev_q  <= pin_s2_q.k;
            kc_prev_q <= pin_s2_q.k_comp;
        end
    end

    wire k_rise   = pin_s2_q.k & ~k_prev_q;
    wire kc_rise  = pin_s2_q.k_comp & ~kc_prev_q;
    wire op_start = k_rise & ~pin_s2_q.load_n;
    wire rd_start = op_start & pin_s2_q.rd_sel;
    wire wr_start = op_start & ~pin_s2_q.rd_sel;

    localparam sbi_pkg::sbi_data_t DATA_EN = NARROW ? `SBI_NARROW_EN : `SBI_WIDE_EN;
    localparam sbi_pkg::sbi_mask_t LANE_EN = NARROW ? 4'h3 : 4'hf;
    // unused lanes of the narrow part read as masked so they are never written
    wire sbi_pkg::sbi_mask_t mask_eff = pin_s2_q.mask_n | ~LANE_EN;

    // ==========================================================
    // read pipeline, one stage per true clock rise
    sbi_pkg::sbi_req_s rd_q [3];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_q[0] <= '0;
            rd_q[1] <= '0;
            rd_q[2] <= '0;
        end else if (k_rise) begin
            rd_q[0] <= '{valid: rd_start, addr: pin_s2_q.addr};
            rd_q[1] <= rd_q[0];
            rd_q[2] <= rd_q[1];
        end
    end

    // ==========================================================
    // write capture and posted-write register
    sbi_pkg::sbi_req_s  wr_pend_q;
    sbi_pkg::sbi_req_s  wr_half_q;
    sbi_pkg::sbi_data_t w0_q;
    sbi_pkg::sbi_mask_t m0_q;
    sbi_pkg::sbi_post_s post_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_pend_q <= '0;
            wr_half_q <= '0;
            w0_q      <= '0;
            m0_q      <= '1;
            post_q    <= '0;
        end else begin
            if (kc_rise && wr_half_q.valid) begin
                // second word with its own mask, then the burst is posted
                post_q <= '{valid: 1'b1, addr: wr_half_q.addr, w0: w0_q,
                            w1: pin_s2_q.data, m0: m0_q, m1: mask_eff};
                wr_half_q.valid <= 1'b0;
            end
            if (k_rise) begin
                wr_pend_q <= '{valid: wr_start, addr: pin_s2_q.addr};
                wr_half_q <= wr_pend_q;
                if (wr_pend_q.valid) begin
                    w0_q <= pin_s2_q.data;
                    m0_q <= mask_eff;
                end
            end
        end
    end

    // older posted burst reaches the array when the next one is complete
    wire commit = kc_rise & wr_half_q.valid & post_q.valid;

    // ==========================================================
    // storage and per-lane merge
    sbi_pkg::sbi_data_t mem_q [`SBI_WORDS];

    wire [`SBI_ADDR_W:0] idx_c0 = {post_q.addr, 1'b0};
    wire [`SBI_ADDR_W:0] idx_c1 = {post_q.addr, 1'b1};
    wire [`SBI_ADDR_W:0] idx_r0 = {rd_q[2].addr, 1'b0};
    wire [`SBI_ADDR_W:0] idx_r1 = {rd_q[2].addr, 1'b1};
    wire sbi_pkg::sbi_data_t arr_c0 = mem_q[idx_c0];
    wire sbi_pkg::sbi_data_t arr_c1 = mem_q[idx_c1];
    wire sbi_pkg::sbi_data_t arr_r0 = mem_q[idx_r0];
    wire sbi_pkg::sbi_data_t arr_r1 = mem_q[idx_r1];
    wire                     rd_hit = post_q.valid && (post_q.addr == rd_q[2].addr);
    wire sbi_pkg::sbi_data_t new_c0;
    wire sbi_pkg::sbi_data_t new_c1;
    wire sbi_pkg::sbi_data_t byp_r0;
    wire sbi_pkg::sbi_data_t byp_r1;

    for (genvar g = 0; g < `SBI_LANES; g++) begin : g_lane
        localparam int LO = g * `SBI_LANE_W;
        wire [`SBI_LANE_W-1:0] w0_l = post_q.w0[LO +: `SBI_LANE_W];
        wire [`SBI_LANE_W-1:0] w1_l = post_q.w1[LO +: `SBI_LANE_W];
        wire [`SBI_LANE_W-1:0] c0_l = arr_c0[LO +: `SBI_LANE_W];
        wire [`SBI_LANE_W-1:0] c1_l = arr_c1[LO +: `SBI_LANE_W];
        wire [`SBI_LANE_W-1:0] r0_l = arr_r0[LO +: `SBI_LANE_W];
        wire [`SBI_LANE_W-1:0] r1_l = arr_r1[LO +: `SBI_LANE_W];
        // a high select keeps the stored lane
        assign new_c0[LO +: `SBI_LANE_W] = post_q.m0[g] ? c0_l : w0_l;
        assign new_c1[LO +: `SBI_LANE_W] = post_q.m1[g] ? c1_l : w1_l;
        assign byp_r0[LO +: `SBI_LANE_W] = (rd_hit && !post_q.m0[g]) ? w0_l : r0_l;
        assign byp_r1[LO +: `SBI_LANE_W] = (rd_hit && !post_q.m1[g]) ? w1_l : r1_l;
    end

    always_ff @(posedge core_clk) begin
        if (commit) begin
            mem_q[idx_c0] <= new_c0;
            mem_q[idx_c1] <= new_c1;
        end
    end

    wire sbi_pkg::sbi_data_t rd_word0 = byp_r0 & DATA_EN;
    wire sbi_pkg::sbi_data_t rd_word1 = byp_r1 & DATA_EN;

    // ==========================================================
    // output drive; no clock edge means nothing changes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dq_oe  <= 1'b0;
            dq_out <= '0;
        end else if (kc_rise) begin
            dq_oe <= rd_q[2].valid;
            if (rd_q[2].valid) begin
                dq_out <= rd_word0;
            end
        end else if (k_rise && rd_q[2].valid) begin
            dq_out <= rd_word1;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_word0_due;
        kc_rise && rd_q[2].valid;
    endsequence
    sequence s_word1_due;
        k_rise && !kc_rise && rd_q[2].valid;
    endsequence

    AST_RESET_QUIET: assert property (disable iff (1'b0) rst |=> !dq_oe)
        else $error("bus driven after reset");
    AST_READ_WORD0: assert property (s_word0_due |=> dq_oe && dq_out == $past(rd_word0))
        else $error("first read word wrong");
    AST_READ_WORD1: assert property (s_word1_due |=> dq_oe && dq_out == $past(rd_word1))
        else $error("second read word wrong");
    AST_RELEASE: assert property (kc_rise && !rd_q[2].valid |=> !dq_oe)
        else $error("bus not released");
    AST_NO_OP: assert property (k_rise && pin_s2_q.load_n |=>
                                !wr_pend_q.valid && !rd_q[0].valid)
        else $error("operation started while not loaded");
    AST_WRITE_FLOW: assert property (wr_start ##1 (!k_rise)[*1] |-> wr_pend_q.valid)
        else $error("write not registered");
    AST_POSTED: assert property (kc_rise && wr_half_q.valid && !k_rise |=> post_q.valid
                                 && post_q.w1 == $past(pin_s2_q.data))
        else $error("second write word not posted");
    // unused narrow lanes are never written, so only enabled lanes are compared
    AST_MASK_ALL: assert property (commit && (&post_q.m0) |=>
                                   (mem_q[$past(idx_c0)] & DATA_EN) == ($past(arr_c0) & DATA_EN))
        else $error("masked word altered array");
    AST_LANE0_W: assert property (commit && !post_q.m0[0] |=>
                                  mem_q[$past(idx_c0)][8:0] == $past(post_q.w0[8:0]))
        else $error("lane 0 not written");
    AST_LANE3_KEEP: assert property (commit && LANE_EN[3] && post_q.m1[3] |=>
                                     mem_q[$past(idx_c1)][35:27] == $past(arr_c1[35:27]))
        else $error("masked lane of second word altered");
    AST_BYPASS: assert property ((s_word0_due and (rd_hit && !post_q.m0[1])) |=>
                                 dq_out[17:9] == $past(post_q.w0[17:9]))
        else $error("read missed posted data");
endmodule

// file: sim/sbi_ctrl_model.sv
// ==========================================
// memory controller: clocks, controls, write data
module sbi_ctrl_model (
    input  wire logic          core_clk,          // system clock
    input  wire logic          rst,               // sync reset
    input  wire logic          halt,              // stops both clocks
    output logic               k_pin,             // true clock
    output logic               k_comp_pin,        // complemented clock
    output logic               address_latch_n,   // load strobe
    output logic               rd_sel,            // high read
    output sbi_pkg::sbi_addr_t addr,              // burst address
    output sbi_pkg::sbi_data_t dq_in,             // write data
    output sbi_pkg::sbi_mask_t lane_write_mask_n, // lane selects
    output logic [3:0]         ph_q               // clock phase
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic               op;
        logic               rd;
        sbi_pkg::sbi_addr_t a;
        sbi_pkg::sbi_data_t d0;
        sbi_pkg::sbi_data_t d1;
        sbi_pkg::sbi_mask_t m0;
        sbi_pkg::sbi_mask_t m1;
    } sbi_cmd_s;
    sbi_cmd_s cq[$];
    sbi_cmd_s cmd, cs_q, ds_q;

    initial {ph_q, address_latch_n, rd_sel, addr, dq_in, lane_write_mask_n} = {4'h0, 1'b1, 45'h0};
    // twelve core cycles a period keeps each phase above the synchroniser minimum
    assign k_pin      = ph_q < 4'h6;
    // a stop keeps whatever level each clock had; both high is only advised
    assign k_comp_pin = !k_pin;

    task automatic push(input logic [85:0] c);
        cq.push_back(sbi_cmd_s'(c));
    endtask

    always @(posedge core_clk) begin
        if (rst) begin
            ph_q <= 4'h0;
            address_latch_n <= 1'b1;
            cs_q <= '0;
            ds_q <= '0;
        end else if (!halt) begin
            ph_q <= (ph_q == 4'hb) ? 4'h0 : ph_q + 4'h1;
            if (ph_q == 4'h8) begin
                cmd = (cq.size() != 0) ? cq.pop_front() : '0;
                address_latch_n <= !cmd.op;
                // released lines show the inverse, never a stale copy
                rd_sel <= cmd.op ? cmd.rd : !rd_sel;
                addr <= cmd.op ? cmd.a : ~addr;
                dq_in <= (cs_q.op && !cs_q.rd) ? cs_q.d0 : ~dq_in;
                lane_write_mask_n <= (cs_q.op && !cs_q.rd) ? cs_q.m0 : ~lane_write_mask_n;
                ds_q <= cs_q;
                cs_q <= cmd;
            end
            if (ph_q == 4'h2 && ds_q.op && !ds_q.rd) begin
                dq_in <= ds_q.d1;
                lane_write_mask_n <= ds_q.m1;
            end
        end
    end
endmodule

// file: sim/sbi_top_tb_top.sv
module sbi_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               core_clk = 1'b0;
    logic               rst = 1'b1;
    logic               halt = 1'b0;
    logic               k_pin, k_comp_pin, address_latch_n, rd_sel, dq_oe, dq_oe_n;
    sbi_pkg::sbi_addr_t addr;
    sbi_pkg::sbi_data_t dq_in, dq_out, dq_out_n;
    sbi_pkg::sbi_mask_t lane_write_mask_n;
    logic [3:0]         ph, ph_last = 4'h0, pipe = 4'h0;
    wire                oe_due = (ph == 4'h4) ? pipe[3] : pipe[2];
    logic [35:0]        mem [32];
    logic [35:0]        exp_q [$];
    logic [35:0]        e, hold, r;
    logic [31:0]        seed = 32'hd018;
    logic               last_rd = 1'b0;
    int                 num_errors = 0;
    int                 check_count = 0;

    initial forever #25 core_clk = !core_clk;

    sbi_ctrl_model u_sbi_ctrl_model (.core_clk, .rst, .halt, .k_pin, .k_comp_pin,
        .address_latch_n, .rd_sel, .addr, .dq_in, .lane_write_mask_n, .ph_q(ph));
    sbi_top u_sbi_top (.core_clk, .rst, .k_pin, .k_comp_pin, .address_latch_n,
        .rd_sel, .addr, .dq_in, .lane_write_mask_n, .dq_out, .dq_oe);
    sbi_top #(.NARROW(1'b1)) u_sbi_top_narrow (.core_clk, .rst, .k_pin, .k_comp_pin,
        .address_latch_n, .rd_sel, .addr, .dq_in, .lane_write_mask_n,
        .dq_out(dq_out_n), .dq_oe(dq_oe_n));

    function automatic logic [35:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return {seed[31:28], seed};
    endfunction

    task automatic chk(input string n, input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
        end
    endtask

    // ==========================================
    // driver: queues the burst and notes what a read must return
    task automatic op(input logic rd, input logic [3:0] a, input logic [35:0] d0, d1,
                      input logic [3:0] m0, m1);
        logic [35:0] d;
        logic [3:0]  m;
        if (!rd && last_rd) repeat (2) u_sbi_ctrl_model.push('0);
        u_sbi_ctrl_model.push({1'b1, rd, a, d0, d1, m0, m1});
        for (int w = 0; w < 2; w++) begin
            d = w ? d1 : d0;
            m = w ? m1 : m0;
            if (rd) exp_q.push_back(mem[{a, w[0]}]);
            else for (int l = 0; l < 4; l++) if (!m[l]) mem[{a, w[0]}][9*l +: 9] = d[9*l +: 9];
        end
        last_rd = rd;
    endtask

    task automatic drain();
        for (int i = 0; i < 30000 && exp_q.size() != 0; i++) @(posedge core_clk);
        repeat (48) @(posedge core_clk);
    endtask

    task automatic end_of_test();
        chk("left over", 36'(exp_q.size()), 36'h0);
        if (num_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================
    // monitor: read words are due at fixed half cycles after the command
    always @(posedge core_clk) begin
        ph_last <= ph;
        if (rst) pipe <= 4'h0;
        else if (ph != ph_last) begin
            if (ph == 4'h0) pipe <= {pipe[2:0], !address_latch_n && rd_sel};
            if (ph == 4'h4 || ph == 4'ha) begin
                chk("oe", 36'(dq_oe), 36'(oe_due));
                chk("oe narrow", 36'(dq_oe_n), 36'(oe_due));
                if (dq_oe === 1'b1 && exp_q.size() != 0) begin
                    e = exp_q.pop_front();
                    chk("dq", dq_out, e);
                    chk("dq narrow", dq_out_n, {18'h0, e[17:0]});
                end
            end
        end
    end

    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) op(1'b0, i[3:0], rnd(), rnd(), 4'h0, 4'h0);
        for (int i = 0; i < 16; i++) op(1'b1, i[3:0], '0, '0, 4'h0, 4'h0);
        op(1'b0, 4'h5, rnd(), rnd(), 4'h3, 4'hc);
        op(1'b1, 4'h5, '0, '0, 4'h0, 4'h0);
        op(1'b0, 4'h7, rnd(), rnd(), 4'hf, 4'h8);
        op(1'b0, 4'h6, rnd(), rnd(), 4'hc, 4'h3);
        op(1'b1, 4'h6, '0, '0, 4'h0, 4'h0);
        op(1'b1, 4'h7, '0, '0, 4'h0, 4'h0);
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            if (r[20]) u_sbi_ctrl_model.push('0);
            op(r[4], r[3:0], rnd(), rnd(), (r[7:5] == 0) ? 4'hf : r[11:8],
               (r[14:12] == 0) ? 4'hf : r[18:15]);
        end
        drain();
        op(1'b1, 4'h3, '0, '0, 4'h0, 4'h0);
        for (int i = 0; i < 400 && dq_oe !== 1'b1; i++) @(posedge core_clk);
        halt <= 1'b1;
        repeat (4) @(posedge core_clk);
        hold = dq_out;
        repeat (16) begin
            @(posedge core_clk);
            chk("stopped dq", dq_out, hold);
            chk("stopped oe", 36'(dq_oe), 36'h1);
        end
        halt <= 1'b0;
        drain();
        end_of_test();
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        end_of_test();
    end
endmodule
